// ### rtl/disp_cfg.svh
// Constants for the display command block: codes, field positions, reset values.
// Assumes inclusion by bare name from each design file that needs them.
`ifndef DISP_CFG_SVH
`define DISP_CFG_SVH

`define CMD_MEM_RD_START 8'h2e
`define CMD_MEM_RD_CONT  8'h3e
`define CMD_MEM_WR_START 8'h2c
`define CMD_MEM_WR_CONT  8'h3c
`define CMD_TEAR_LINE    8'h44
`define CMD_GET_LINE     8'h45
`define CMD_SUPPLIER_RD  8'ha1
`define CMD_PROTECT      8'hb0
`define CMD_FRAME_ACCESS 8'hb3
`define PROT_LVL1_BASE   8'hf0
`define PROT_LVL2_BASE   8'he0
`define EXIT_CODE        8'hff

`define WRAP_BIT         1
`define FMT_BIT          0
`define EXP_HI           5
`define EXP_LO           4

`define WRAP_RST         1'b1
`define TEI_RST          3'h0
`define RGB_WRITE_CYCLE_RST         3'h0
`define FMT_RST          1'b0
`define EXP_RST          2'h0
`define TEAR_LINE_RST    9'h000
`define PROT_RST         2'h0

`endif

// ### rtl/disp_pkg.sv
// Types shared by the display command block and its helpers.
// Assumes nothing beyond a SystemVerilog compiler.
package disp_pkg;
	typedef logic [8:0] coord_t;

	typedef struct packed {
		coord_t start_column;
		coord_t end_column;
		coord_t start_page;
		coord_t end_page;
	} window_s;

	typedef struct packed {
		logic       write_wrap_flag;
		logic [2:0] tear_interval;
		logic [2:0] rgb_write_cycle;
		logic [1:0] color_expand_code;
		logic       frame_format_flag;
	} frame_access_s;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_SKIP,
		ST_TEAR,
		ST_PROT,
		ST_FMA,
		ST_MEMRD,
		ST_LINE_RD,
		ST_ID_RD,
		ST_PIX_WR
	} cmd_state_e;
endpackage : disp_pkg

// ### rtl/color_expand.sv
// Widens a 16-bit pixel to the 18-bit frame memory format.
// Assumes the pixel is packed red, green, blue from the top bit down.
`timescale 1ns/100ps
`default_nettype none
module color_expand (
	input  wire logic [15:0] pix16,
	input  wire logic [1:0]  color_expand_code,
	output logic      [17:0] pix18
);
	function automatic logic [5:0] widen(input logic [4:0] v, input logic [1:0] c);
		logic [5:0] w;
		w = {v, 1'b0};
		case (c)
			2'h0: w = (v == 5'h1f) ? 6'h3f : {v, 1'b0};
			2'h1: w = (v == 5'h00) ? 6'h00 : {v, 1'b1};
			2'h2: w = {v, v[4]};
			default: w = {v, 1'b0};
		endcase
		return w;
	endfunction : widen

	// Code 11 is disabled; it falls back to the plain zero fill.
	assign pix18 = {widen(pix16[15:11], color_expand_code), pix16[10:5],
		widen(pix16[4:0], color_expand_code)};
endmodule : color_expand
`default_nettype wire

// ### rtl/window_counter.sv
// Column and page counter that walks the address window.
// Assumes load and step are single-cycle pulses from the same clock.
`timescale 1ns/100ps
`default_nettype none
module window_counter (
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	input  wire disp_pkg::window_s win,
	input  wire logic             page_first,
	input  wire logic             wrap_en,
	input  wire logic             load,
	input  wire logic             step,
	output disp_pkg::coord_t      col_r,
	output disp_pkg::coord_t      page_r,
	output logic                  done_r
);
	import disp_pkg::*;

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			col_r  <= 9'h000;
			page_r <= 9'h000;
			done_r <= 1'b0;
		end
		else if (load)
		begin
			col_r  <= win.start_column;
			page_r <= win.start_page;
			done_r <= 1'b0;
		end
		else if (step && !done_r)
		begin
			if (!page_first)
			begin
				if (col_r == win.end_column)
				begin
					col_r <= win.start_column;
					if (page_r == win.end_page)
					begin
						page_r <= win.start_page;
						done_r <= !wrap_en;
					end
					else
						page_r <= page_r + 9'h001;
				end
				else
					col_r <= col_r + 9'h001;
			end
			else
			begin
				if (page_r == win.end_page)
				begin
					page_r <= win.start_page;
					if (col_r == win.end_column)
					begin
						col_r  <= win.start_column;
						done_r <= !wrap_en;
					end
					else
						col_r <= col_r + 9'h001;
				end
				else
					page_r <= page_r + 9'h001;
			end
		end
	end
endmodule : window_counter
`default_nettype wire

// ### rtl/display_cmd_memread_tear_setup.sv
// Command interpreter for memory readback, tear setup, ID readback and access settings.
// Assumes DBI pins arrive asynchronously, timing pulses come from the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "disp_cfg.svh"
module display_cmd_memread_tear_setup #(
	parameter logic [15:0] SUPPLIER_CODE          = 16'h5a5a,  // Arbitrary value.
	parameter logic [15:0] SUPPLIER_ELECTIVE_CODE = 16'h1234   // Arbitrary value.
) (
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	input  wire logic              soft_reset,
	input  wire logic              chip_select_n,
	input  wire logic              data_command_select,
	input  wire logic              read_strobe_n,
	input  wire logic              write_strobe_n,
	input  wire logic [17:0]       db_in,
	output logic      [17:0]       db_out,
	output logic                   db_oe_n,
	input  wire logic              sleep_mode,
	input  wire logic              tear_enable,
	input  wire logic              frame_start,
	input  wire logic              line_start,
	input  wire logic              bus_16bit_mode,
	input  wire logic              page_first,
	input  wire disp_pkg::window_s win,
	output disp_pkg::coord_t       mem_rd_col,
	output disp_pkg::coord_t       mem_rd_page,
	input  wire logic [17:0]       mem_rd_data,
	output logic                   mem_wr_en,
	output disp_pkg::coord_t       mem_wr_col,
	output disp_pkg::coord_t       mem_wr_page,
	output logic      [17:0]       mem_wr_data,
	output logic                   tear_effect_output,
	output logic                   rgb_write_permit,
	output logic                   frame_format_flag,
	output logic      [1:0]        command_protect_level
);
	import disp_pkg::*;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [20:0] pin_s1_r;
	logic [20:0] pin_s2_r;
	logic        rd_d_r;
	logic        wr_d_r;
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_s1_r <= {3'h7, 18'h00000};
			pin_s2_r <= {3'h7, 18'h00000};
			rd_d_r   <= 1'b1;
			wr_d_r   <= 1'b1;
		end
		else
		begin
			pin_s1_r <= {chip_select_n, read_strobe_n, write_strobe_n, db_in};
			pin_s2_r <= pin_s1_r;
			rd_d_r   <= pin_s2_r[19];
			wr_d_r   <= pin_s2_r[18];
		end
	end

	logic        cs_n_s;
	logic        rd_n_s;
	logic        wr_n_s;
	logic [17:0] dbs;
	logic        dcx_s1_r;
	logic        dcx_s2_r;
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			dcx_s1_r <= 1'b0;
			dcx_s2_r <= 1'b0;
		end
		else
		begin
			dcx_s1_r <= data_command_select;
			dcx_s2_r <= dcx_s1_r;
		end
	end
	assign cs_n_s = pin_s2_r[20];
	assign rd_n_s = pin_s2_r[19];
	assign wr_n_s = pin_s2_r[18];
	assign dbs    = pin_s2_r[17:0];

	// A strobe counts at its rising edge, when the host has finished with the bus.
	logic wr_rise;
	logic rd_rise;
	logic cmd_wr;
	logic data_wr;
	assign wr_rise = wr_n_s && !wr_d_r && !cs_n_s;
	assign rd_rise = rd_n_s && !rd_d_r && !cs_n_s;
	assign cmd_wr  = wr_rise && !dcx_s2_r;
	assign data_wr = wr_rise && dcx_s2_r;

	// ------------------------------------------------------------
	// Command decode and protect
	// ------------------------------------------------------------
	cmd_state_e    st_r;
	cmd_state_e    st_nxt;
	logic [2:0]    idx_r;
	frame_access_s fma_r;
	logic [8:0]    tear_line_r;
	logic [8:0]    scan_r;
	logic [8:0]    line_snap_r;
	logic          blocked;
	logic [7:0]    cmd;
	assign cmd = dbs[7:0];

	always_comb
	begin
		blocked = 1'b0;
		if (command_protect_level == 2'h1)
			blocked = (cmd >= `PROT_LVL1_BASE);
		else if (command_protect_level[1])
			blocked = (cmd >= `PROT_LVL2_BASE);
	end

	always_comb
	begin
		st_nxt = ST_SKIP;
		if (blocked)
			st_nxt = ST_SKIP;
		else
		begin
			case (cmd)
				`CMD_MEM_RD_START: st_nxt = ST_MEMRD;
				`CMD_MEM_RD_CONT:  st_nxt = ST_MEMRD;
				`CMD_MEM_WR_START: st_nxt = ST_PIX_WR;
				`CMD_MEM_WR_CONT:  st_nxt = ST_PIX_WR;
				`CMD_TEAR_LINE:    st_nxt = ST_TEAR;
				`CMD_GET_LINE:     st_nxt = ST_LINE_RD;
				`CMD_SUPPLIER_RD:  st_nxt = ST_ID_RD;
				`CMD_PROTECT:      st_nxt = ST_PROT;
				`CMD_FRAME_ACCESS: st_nxt = ST_FMA;
				default:           st_nxt = ST_SKIP;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_r  <= ST_IDLE;
			idx_r <= 3'h0;
		end
		else if (soft_reset)
		begin
			st_r  <= ST_IDLE;
			idx_r <= 3'h0;
		end
		else if (cmd_wr)
		begin
			st_r  <= st_nxt;
			idx_r <= 3'h0;
		end
		else if ((data_wr || rd_rise) && idx_r != 3'h7)
			idx_r <= idx_r + 3'h1;
	end

	// ------------------------------------------------------------
	// Settings; software reset leaves them alone
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			fma_r.write_wrap_flag   <= `WRAP_RST;
			fma_r.tear_interval     <= `TEI_RST;
			fma_r.rgb_write_cycle   <= `RGB_WRITE_CYCLE_RST;
			fma_r.color_expand_code <= `EXP_RST;
			fma_r.frame_format_flag <= `FMT_RST;
		end
		else if (data_wr && st_r == ST_FMA)
		begin
			case (idx_r)
				3'h0: fma_r.write_wrap_flag <= dbs[`WRAP_BIT];
				3'h1: fma_r.tear_interval <= dbs[2:0];
				3'h2: fma_r.rgb_write_cycle <= dbs[2:0];
				3'h3:
				begin
					fma_r.color_expand_code <= dbs[`EXP_HI:`EXP_LO];
					fma_r.frame_format_flag <= dbs[`FMT_BIT];
				end
				default: fma_r.write_wrap_flag <= fma_r.write_wrap_flag;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			tear_line_r <= `TEAR_LINE_RST;
		else if (data_wr && st_r == ST_TEAR && idx_r == 3'h0)
			tear_line_r[8] <= dbs[0];
		else if (data_wr && st_r == ST_TEAR && idx_r == 3'h1)
			tear_line_r[7:0] <= dbs[7:0];
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			command_protect_level <= `PROT_RST;
		else if (data_wr && st_r == ST_PROT && idx_r == 3'h0)
			command_protect_level <= dbs[1:0];
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			frame_format_flag <= `FMT_RST;
		else
			frame_format_flag <= fma_r.frame_format_flag;
	end

	// ------------------------------------------------------------
	// Scan line, tear and RGB write cycle
	// ------------------------------------------------------------
	logic [2:0] tear_cnt_r;
	logic [2:0] tear_last;
	logic [2:0] rgb_cnt_r;
	always_comb
	begin
		case (fma_r.tear_interval)
			3'b001:  tear_last = 3'h1;
			3'b011:  tear_last = 3'h3;
			3'b101:  tear_last = 3'h5;
			default: tear_last = 3'h0;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			scan_r <= 9'h000;
		else if (frame_start)
			scan_r <= 9'h000;
		else if (line_start)
			scan_r <= scan_r + 9'h001;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tear_cnt_r <= 3'h0;
			rgb_cnt_r  <= 3'h0;
		end
		else if (frame_start)
		begin
			tear_cnt_r <= (tear_cnt_r >= tear_last) ? 3'h0 : tear_cnt_r + 3'h1;
			rgb_cnt_r  <= (rgb_cnt_r >= fma_r.rgb_write_cycle) ? 3'h0 : rgb_cnt_r + 3'h1;
		end
	end

	// Address mode B4 never enters here, so line order cannot shift the tear.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			tear_effect_output <= 1'b0;
		else if (sleep_mode)
			tear_effect_output <= 1'b0;
		else
			tear_effect_output <= tear_enable && tear_cnt_r == 3'h0 &&
				scan_r == tear_line_r;
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			rgb_write_permit <= 1'b0;
		else
			rgb_write_permit <= (rgb_cnt_r == 3'h0);
	end

	// The line is caught at the command; in sleep it is stale and meaningless.
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			line_snap_r <= 9'h000;
		else if (cmd_wr && cmd == `CMD_GET_LINE)
			line_snap_r <= scan_r;
	end

	// ------------------------------------------------------------
	// Frame memory read and write walkers
	// ------------------------------------------------------------
	logic rd_load;
	logic rd_step;
	logic rd_done;
	logic wr_load;
	logic wr_step;
	logic wr_done;
	coord_t wcol;
	coord_t wpage;
	logic [17:0] pix18;
	// Read start reloads; read continue keeps the walker where it stopped.
	assign rd_load = cmd_wr && !blocked && cmd == `CMD_MEM_RD_START;
	assign rd_step = rd_rise && st_r == ST_MEMRD && idx_r != 3'h0;
	assign wr_load = cmd_wr && !blocked && cmd == `CMD_MEM_WR_START;
	assign wr_step = data_wr && st_r == ST_PIX_WR;

	window_counter u_rd_walk (
		.ref_clk    (ref_clk),
		.resetn     (resetn),
		.win        (win),
		.page_first (page_first),
		.wrap_en    (1'b0),
		.load       (rd_load),
		.step       (rd_step),
		.col_r      (mem_rd_col),
		.page_r     (mem_rd_page),
		.done_r     (rd_done)
	);

	window_counter u_wr_walk (
		.ref_clk    (ref_clk),
		.resetn     (resetn),
		.win        (win),
		.page_first (page_first),
		.wrap_en    (fma_r.write_wrap_flag),
		.load       (wr_load),
		.step       (wr_step),
		.col_r      (wcol),
		.page_r     (wpage),
		.done_r     (wr_done)
	);

	color_expand u_expand (
		.pix16             (dbs[15:0]),
		.color_expand_code (fma_r.color_expand_code),
		.pix18             (pix18)
	);

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mem_wr_en   <= 1'b0;
			mem_wr_col  <= 9'h000;
			mem_wr_page <= 9'h000;
			mem_wr_data <= 18'h00000;
		end
		else
		begin
			mem_wr_en <= wr_step && !wr_done;
			if (wr_step)
			begin
				mem_wr_col  <= wcol;
				mem_wr_page <= wpage;
				mem_wr_data <= bus_16bit_mode ? pix18 : dbs;
			end
		end
	end

	// ------------------------------------------------------------
	// Read data return
	// ------------------------------------------------------------
	logic [17:0] rd_word;
	always_comb
	begin
		rd_word = 18'h00000;
		if (idx_r != 3'h0)
		begin
			case (st_r)
				ST_MEMRD:   rd_word = rd_done ? 18'h00000 : mem_rd_data;
				ST_LINE_RD: rd_word = (idx_r == 3'h1) ? {17'h00000, line_snap_r[8]} :
					(idx_r == 3'h2) ? {10'h000, line_snap_r[7:0]} : 18'h00000;
				ST_ID_RD:
				begin
					case (idx_r)
						3'h1:    rd_word = {10'h000, SUPPLIER_ELECTIVE_CODE[15:8]};
						3'h2:    rd_word = {10'h000, SUPPLIER_ELECTIVE_CODE[7:0]};
						3'h3:    rd_word = {10'h000, SUPPLIER_CODE[15:8]};
						3'h4:    rd_word = {10'h000, SUPPLIER_CODE[7:0]};
						default: rd_word = {10'h000, `EXIT_CODE};
					endcase
				end
				default:    rd_word = 18'h00000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			db_out  <= 18'h00000;
			db_oe_n <= 1'b1;
		end
		else
		begin
			db_out  <= rd_word;
			db_oe_n <= !(!cs_n_s && !rd_n_s && dcx_s2_r &&
				(st_r == ST_MEMRD || st_r == ST_LINE_RD || st_r == ST_ID_RD));
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_tear_sleep;
		@(posedge ref_clk) disable iff (!resetn) sleep_mode |=> !tear_effect_output;
	endproperty
	a_tear_sleep: assert property (p_tear_sleep) else $error("tear active in sleep");

	property p_tear_line;
		@(posedge ref_clk) disable iff (!resetn)
			$rose(tear_effect_output) |-> $past(scan_r) == $past(tear_line_r);
	endproperty
	a_tear_line: assert property (p_tear_line) else $error("tear on wrong line");

	property p_prot1;
		@(posedge ref_clk) disable iff (!resetn || soft_reset)
			cmd_wr && command_protect_level == 2'h1 && cmd >= 8'hf0 |=> st_r == ST_SKIP;
	endproperty
	a_prot1: assert property (p_prot1) else $error("level 1 let F0-FF through");

	property p_prot3;
		@(posedge ref_clk) disable iff (!resetn || soft_reset)
			cmd_wr && command_protect_level == 2'h3 && cmd >= 8'he0 |=> st_r == ST_SKIP;
	endproperty
	a_prot3: assert property (p_prot3) else $error("level 3 let E0-FF through");

	property p_blocked_keeps;
		@(posedge ref_clk) disable iff (!resetn)
			st_r == ST_SKIP && data_wr |=> $stable(fma_r) && $stable(tear_line_r);
	endproperty
	a_blocked_keeps: assert property (p_blocked_keeps) else $error("skipped data changed");

	property p_fma_wrap;
		@(posedge ref_clk) disable iff (!resetn)
			data_wr && st_r == ST_FMA && idx_r == 3'h0 |=>
				fma_r.write_wrap_flag == $past(dbs[1]);
	endproperty
	a_fma_wrap: assert property (p_fma_wrap) else $error("wrap flag not taken");

	property p_scan_zero;
		@(posedge ref_clk) disable iff (!resetn) frame_start |=> scan_r == 9'h000;
	endproperty
	a_scan_zero: assert property (p_scan_zero) else $error("scan line not zero");

	property p_memrd_dummy;
		@(posedge ref_clk) disable iff (!resetn || soft_reset)
			cmd_wr && !blocked && cmd == 8'h3e |=> ##1 db_out == 18'h00000;
	endproperty
	a_memrd_dummy: assert property (p_memrd_dummy) else $error("no dummy word");

	property p_discard;
		@(posedge ref_clk) disable iff (!resetn)
			wr_step && wr_done |=> !mem_wr_en;
	endproperty
	a_discard: assert property (p_discard) else $error("pixel written past window");

	property p_rgb_cycle;
		@(posedge ref_clk) disable iff (!resetn)
			frame_start && rgb_cnt_r == fma_r.rgb_write_cycle |=> ##1 rgb_write_permit;
	endproperty
	a_rgb_cycle: assert property (p_rgb_cycle) else $error("rgb cycle wrong");

	c_tear: cover property (@(posedge ref_clk) disable iff (!resetn) $rose(tear_effect_output));
	c_wrap: cover property (@(posedge ref_clk) disable iff (!resetn)
		wr_step && fma_r.write_wrap_flag && wcol == win.end_column && wpage == win.end_page);
	c_idrd: cover property (@(posedge ref_clk) disable iff (!resetn)
		st_r == ST_ID_RD && idx_r == 3'h5 && rd_rise);
endmodule : display_cmd_memread_tear_setup
`default_nettype wire

// ### bench/dbi_host.sv
// Host processor model that drives the display command link.
// Assumes the bench calls its tasks; strobes move on the falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module dbi_host (
	input  wire logic        ref_clk,
	input  wire logic [17:0] db_out,
	input  wire logic        db_oe_n,
	output logic             cs_n,
	output logic             dcx,
	output logic             rd_n,
	output logic             wr_n,
	output logic      [17:0] db
);
	logic oe_seen;

	initial
	begin
		cs_n = 1'b1;
		dcx  = 1'b0;
		rd_n = 1'b1;
		wr_n = 1'b1;
		db   = 18'h0;
	end

	// Data is held past the rising strobe so the synchronised sample sees it.
	task wr_word(input logic d, input logic [17:0] v);
		@(negedge ref_clk);
		cs_n = 1'b0;
		dcx  = d;
		db   = v;
		wr_n = 1'b0;
		repeat (5) @(negedge ref_clk);
		wr_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		db = ~v;
	endtask : wr_word

	task rd_word(output logic [17:0] v);
		@(negedge ref_clk);
		cs_n = 1'b0;
		dcx  = 1'b1;
		rd_n = 1'b0;
		repeat (7) @(negedge ref_clk);
		v       = db_out;
		oe_seen = db_oe_n;
		rd_n    = 1'b1;
		repeat (4) @(negedge ref_clk);
	endtask : rd_word
endmodule : dbi_host
`default_nettype wire

// ### bench/display_cmd_memread_tear_setup_tb.sv
// Self-checking bench for the display command block.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module display_cmd_memread_tear_setup_tb;
	import disp_pkg::*;
	logic        ref_clk, resetn, sleep_mode, tear_enable, frame_start, line_start;
	logic        cs_n, dcx, rd_n, wr_n, mem_wr_en, tear, ff;
	logic        oe_n, soft_reset, rgb;
	logic [5:0]  tm, rm;
	logic [1:0]  pl;
	logic [17:0] db, db_out, mem_rd_data, mem_wr_data, v;
	window_s     win;
	coord_t      rc, rp, wc, wp;
	logic [31:0] seed;
	logic [35:0] wq[$];
	logic [15:0] pq[$];
	int          num_errors = 0;
	int          n_compared = 0;
	int          cycles = 0;
	int          i, k, s;

	assign mem_rd_data = {rp, rc};

	dbi_host host (.ref_clk(ref_clk), .db_out(db_out), .db_oe_n(oe_n), .cs_n(cs_n),
		.dcx(dcx), .rd_n(rd_n), .wr_n(wr_n), .db(db));

	display_cmd_memread_tear_setup DUT (.ref_clk(ref_clk), .resetn(resetn),
		.soft_reset(soft_reset), .chip_select_n(cs_n), .data_command_select(dcx),
		.read_strobe_n(rd_n), .write_strobe_n(wr_n), .db_in(db), .db_out(db_out),
		.db_oe_n(oe_n), .sleep_mode(sleep_mode), .tear_enable(tear_enable),
		.frame_start(frame_start), .line_start(line_start), .bus_16bit_mode(1'b1),
		.page_first(1'b0), .win(win), .mem_rd_col(rc), .mem_rd_page(rp),
		.mem_rd_data(mem_rd_data), .mem_wr_en(mem_wr_en), .mem_wr_col(wc),
		.mem_wr_page(wp), .mem_wr_data(mem_wr_data), .tear_effect_output(tear),
		.rgb_write_permit(rgb), .frame_format_flag(ff), .command_protect_level(pl));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	function automatic logic [5:0] wid(input logic [4:0] x, input logic [1:0] c);
		case (c)
			2'h0: return (x == 5'h1f) ? 6'h3f : {x, 1'b0};
			2'h1: return (x == 5'h00) ? 6'h00 : {x, 1'b1};
			default: return {x, x[4]};
		endcase
	endfunction : wid

	// Window is columns 1..2, pages 0..1, walked column first.
	function automatic logic [17:0] addr(input int n);
		return {9'((n % 4) / 2), 9'(1 + n % 2)};
	endfunction : addr

	task chk(input logic [17:0] got, input logic [17:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task cmd(input logic [7:0] c);
		host.wr_word(1'b0, {10'h0, c});
	endtask : cmd

	task prm(input logic [7:0] p);
		host.wr_word(1'b1, {10'h0, p});
	endtask : prm

	task line;
		@(negedge ref_clk);
		line_start = 1'b1;
		@(negedge ref_clk);
		line_start = 1'b0;
	endtask : line

	task sreset;
		@(negedge ref_clk);
		soft_reset = 1'b1;
		@(negedge ref_clk);
		soft_reset = 1'b0;
	endtask : sreset

	task stop_test;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	// ------------------------------------------------------------------
	// Clock, timeout and write monitor
	// ------------------------------------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Outputs are sampled half a period after the edge that launches them.
	always @(negedge ref_clk)
	begin
		cycles++;
		if (mem_wr_en === 1'b1)
			wq.push_back({wp, wc, mem_wr_data});
		if (cycles == 20000)
		begin
			num_errors++;
			stop_test();
		end
	end

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	initial
	begin
		{resetn, sleep_mode, tear_enable, frame_start, line_start, soft_reset} = 6'h0;
		win = '{9'h1, 9'h2, 9'h0, 9'h1};
		seed = 32'he5958f12;
		repeat (3) @(negedge ref_clk);
		resetn = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk({15'h0, ff, pl}, 18'h0);
		chk({17'h0, tear}, 18'h0);
		// Last pass sets the wrap flag, so the fifth pixel lands at the start again.
		for (i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			cmd(8'hb3);
			prm({6'h0, i == 3, 1'b0});
			prm(8'h0);
			prm(8'h0);
			prm({2'h0, 2'(i % 3), 3'h0, seed[0]});
			repeat (3) @(negedge ref_clk);
			chk({17'h0, ff}, {17'h0, seed[0]});
			sreset();
			chk({17'h0, ff}, {17'h0, seed[0]});
			cmd(8'h2c);
			repeat (5)
			begin
				seed = lfsr(seed);
				pq.push_back(seed[15:0]);
				host.wr_word(1'b1, {2'h0, seed[15:0]});
			end
			repeat (4) @(negedge ref_clk);
			chk(18'(wq.size()), (i == 3) ? 18'h5 : 18'h4);
			foreach (wq[k])
			begin
				chk(wq[k][35:18], addr(k));
				chk(wq[k][17:0], {wid(pq[k][15:11], 2'(i % 3)), pq[k][10:5],
					wid(pq[k][4:0], 2'(i % 3))});
			end
			wq.delete();
			pq.delete();
		end
		for (i = 1; i < 5; i++)
		begin
			cmd(8'hb0);
			prm(8'(i % 4));
			cmd(8'hf5);
			prm(8'h0);
			repeat (3) @(negedge ref_clk);
			chk({16'h0, pl}, 18'(i % 4));
		end
		cmd(8'h2e);
		host.rd_word(v);
		for (k = 0; k < 3; k++)
		begin
			host.rd_word(v);
			chk(v, addr(k));
		end
		chk({17'h0, oe_n}, 18'h1);
		cmd(8'h3e);
		host.rd_word(v);
		host.rd_word(v);
		chk(v, addr(3));
		cmd(8'ha1);
		host.rd_word(v);
		for (k = 0; k < 5; k++)
		begin
			host.rd_word(v);
			chk(v, {10'h0, 8'(40'h12345a5aff >> (32 - 8 * k))});
			chk({17'h0, host.oe_seen}, 18'h0);
		end
		cmd(8'h44);
		prm(8'h1);
		prm(8'h1);
		sreset();
		tear_enable = 1'b1;
		for (s = 0; s < 2; s++)
		begin
			sleep_mode = s[0];
			@(negedge ref_clk);
			frame_start = 1'b1;
			@(negedge ref_clk);
			frame_start = 1'b0;
			repeat (257) line();
			repeat (3) @(negedge ref_clk);
			chk({17'h0, tear}, {17'h0, s == 0});
			if (s == 0)
			begin
				cmd(8'h45);
				host.rd_word(v);
				host.rd_word(v);
				chk(v, 18'h1);
				host.rd_word(v);
				chk(v, 18'h1);
			end
			line();
			repeat (3) @(negedge ref_clk);
			chk({17'h0, tear}, 18'h0);
		end
		// Tear on line 2 every second frame, RGB writes every third frame.
		cmd(8'h44);
		prm(8'h0);
		prm(8'h2);
		cmd(8'hb3);
		prm(8'h2);
		prm(8'h1);
		prm(8'h2);
		prm(8'h0);
		sleep_mode = 1'b0;
		for (s = 0; s < 6; s++)
		begin
			@(negedge ref_clk);
			frame_start = 1'b1;
			@(negedge ref_clk);
			frame_start = 1'b0;
			repeat (3) @(negedge ref_clk);
			rm[s] = rgb;
			repeat (2) line();
			repeat (3) @(negedge ref_clk);
			tm[s] = tear;
		end
		chk({12'h0, tm}, {12'h0, {3{tm[1:0]}}});
		chk(18'($countones(tm[1:0])), 18'h1);
		chk({12'h0, rm}, {12'h0, {2{rm[2:0]}}});
		chk(18'($countones(rm[2:0])), 18'h1);
		stop_test();
	end
endmodule : display_cmd_memread_tear_setup_tb
`default_nettype wire
